/* hw/cpu_power_mode_controller.sv */
// How it works
// - With gating on, each unit's clock runs only when dispatch needs it.
// - Gating is on only while configuration bit 11 is set.
// - Gating never alters results or timing seen by software or hardware.
// - Full, doze, nap, sleep; exactly one of three mode bits picks low power.
// - An external interrupt raises a flag so a handler may select a mode.
// - A separate power-management interrupt input with its own status bit.
// - Decrementer keeps running in doze and nap and its event wakes to full.
// - Low-power states only ever leave to full power, never to each other.
// - Nap and sleep are entered only after the quiesce handshake completes.
// - Doze keeps snooping and decrementer; wakes on interrupt, decrementer, reset.
// - Nap keeps only the decrementer; wakes on interrupt, decrementer, reset.
// - Sleep stops everything including decrementer; wakes on interrupt or reset.
// - Full power clocks all units; with gating, units clock on demand.
// - Quiesce request goes out; after acknowledge, entry follows a few clocks later.
// - Configuration bits 8, 9, 10 select doze, nap and sleep.
// - Entry happens only when the power-enable bit is set.
// - After reset or hard reset: full power, gating off.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "pm_regs.svh"
module cpu_power_mode_controller
    import pm_pkg::*;
#(
    parameter int         N_UNITS = 5,
    parameter logic [3:0] SETTLE  = `PM_SETTLE_CYC,
    parameter logic [7:0] DEC_DIV = `DEC_DIV_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic      [31:0]        hrdata_o,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    input  wire logic               ext_int_i,
    input  wire logic               power_mgmt_interrupt_i,
    input  wire logic               quiesce_acknowledge_i,
    input  wire logic               hard_reset_in_i,
    input  wire logic [N_UNITS-1:0] unit_req_i,
    output logic      [N_UNITS-1:0] unit_clk_en_o,
    output logic                    quiesce_request_o,
    output logic                    snoop_en_o,
    output logic                    units_halted_o,
    output logic                    dec_running_o,
    output logic                    irq_o
);
    // ****************************************************************
    // Reset image and helpers
    // ****************************************************************
    localparam ctrl_t CTRL_RST = '{
        ps:      PS_FULL,
        tgt:     MODE_NONE,
        hwcfg:   `HWCFG_RST,
        mstate:  `MSTATE_RST,
        dec:     `DEC_RST,
        hready:  1'b1,
        snoop:   1'b1,
        dec_run: 1'b1,
        default: '0
    };

    function automatic logic [31:0] rd_reg(input ctrl_t c, input logic [7:0] ofs);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (ofs)
            `PM_OFS_HWCFG:    v = c.hwcfg;
            `PM_OFS_MSTATE:   v = c.mstate;
            `PM_OFS_STATUS: begin
                v[2:0]                = c.ps;
                v[`STATUS_QUIESCE_REQUEST_BIT]   = c.quiesce_request;
                v[`STATUS_GATE_BIT]   = c.hwcfg[`HWCFG_GATE_BIT];
            end
            `PM_OFS_IRQ_STAT: v[3:0] = c.stat;
            `PM_OFS_IRQ_MASK: v[3:0] = c.mask;
            `PM_OFS_DEC:      v = c.dec;
            default:          v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Exactly one of the three mode bits, else no low-power target
    function automatic mode_t pick_mode(input logic [31:0] cfg);
        mode_t m;
        m = MODE_NONE;
        unique case (cfg[`HWCFG_SLEEP_BIT:`HWCFG_DOZE_BIT])
            3'h1:    m = MODE_DOZE;
            3'h2:    m = MODE_NAP;
            3'h4:    m = MODE_SLEEP;
            default: m = MODE_NONE;
        endcase
        return m;
    endfunction

    // Doze, nap and sleep all hold the units
    function automatic logic is_low(input pstate_t p);
        return p == PS_DOZE || p == PS_NAP || p == PS_SLEEP;
    endfunction

    // Nap and sleep give up snooping, so only they need the handshake
    function automatic logic is_quiet(input pstate_t p);
        return p == PS_NAP || p == PS_SLEEP;
    endfunction

    // The decrementer may wake only the states in which it still runs
    function automatic logic dec_wakes(input pstate_t p);
        return p == PS_DOZE || p == PS_NAP;
    endfunction

    // ****************************************************************
    // Pin synchronisers and unit clock gating
    // ****************************************************************
    logic [3:0] pins_s;

    // Hard reset shares the synchroniser, so it takes effect a few cycles late
    pm_sync #(.W(4)) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({hard_reset_in_i, quiesce_acknowledge_i,
                    power_mgmt_interrupt_i, ext_int_i}),
        .q_o      (pins_s)
    );

    // Unit enables are registered inside, so these outputs stay flops
    gate_if #(.N(N_UNITS)) gif ();

    unit_gate #(.N(N_UNITS)) u_gate (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .gif      (gif)
    );

    ctrl_t s_q;
    ctrl_t s_d;

    assign gif.gating_on = s_q.hwcfg[`HWCFG_GATE_BIT];
    // Hold follows the next state so the unit enables drop on the very edge
    // that the halt flag rises; a registered hold would leave one cycle of
    // unit clocks running inside doze, nap and sleep
    assign gif.hold      = s_d.halt;
    assign gif.req       = unit_req_i;

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic        ev_ext;
    logic        ev_pmi;
    logic        ev_dec;
    logic        tick;
    logic        wake;
    logic        wr_en;
    logic [3:0]  ev_set;
    logic [3:0]  ev_clr;
    mode_t       sel;

    always_comb begin
        s_d      = s_q;
        ev_ext   = pins_s[0] & ~s_q.ext_q;
        ev_pmi   = pins_s[1] & ~s_q.pmi_q;
        s_d.ext_q = pins_s[0];
        s_d.pmi_q = pins_s[1];
        ev_clr   = 4'h0;
        wr_en    = s_q.a_act & s_q.a_wr;

        // Decrementer, stepped by a divided enable; frozen in sleep only
        tick = 1'b0;
        if (s_q.dec_run) begin
            if (s_q.div == 8'h00) begin
                tick      = 1'b1;
                s_d.div   = DEC_DIV - 8'h01;
            end else begin
                s_d.div   = s_q.div - 8'h01;
            end
        end
        ev_dec = tick & (s_q.dec == 32'h0000_0001);
        if (tick) begin
            s_d.dec = s_q.dec - 32'h0000_0001;
        end

        // Register writes in the data phase
        if (wr_en) begin
            case (s_q.a_ofs)
                `PM_OFS_HWCFG:    s_d.hwcfg  = hwdata_i;
                `PM_OFS_MSTATE:   s_d.mstate = hwdata_i;
                `PM_OFS_IRQ_STAT: ev_clr     = hwdata_i[3:0];
                `PM_OFS_IRQ_MASK: s_d.mask   = hwdata_i[3:0];
                `PM_OFS_DEC:      s_d.dec    = hwdata_i;
                default:          s_d.mask   = s_q.mask;
            endcase
        end

        // Power state machine
        sel  = pick_mode(s_q.hwcfg);
        wake = ev_ext | ev_pmi;
        if (dec_wakes(s_q.ps)) begin
            wake = wake | ev_dec;
        end
        unique case (s_q.ps)
            PS_FULL: begin
                if (s_q.mstate[`MSTATE_POW_BIT] && sel != MODE_NONE && !wake) begin
                    s_d.tgt    = sel;
                    s_d.settle = SETTLE - 4'h1;
                    if (sel == MODE_DOZE) begin
                        s_d.ps   = PS_SETTLE;
                    end else begin
                        s_d.ps   = PS_QUIESCE;
                        s_d.quiesce_request = 1'b1;
                    end
                end
            end
            PS_QUIESCE: begin
                if (wake) begin
                    s_d.ps = PS_FULL;
                end else if (pins_s[2]) begin
                    s_d.ps = PS_SETTLE;
                end
            end
            PS_SETTLE: begin
                if (wake) begin
                    s_d.ps = PS_FULL;
                end else if (s_q.settle == 4'h0) begin
                    unique case (s_q.tgt)
                        MODE_NAP:   s_d.ps = PS_NAP;
                        MODE_SLEEP: s_d.ps = PS_SLEEP;
                        default:    s_d.ps = PS_DOZE;
                    endcase
                end else begin
                    s_d.settle = s_q.settle - 4'h1;
                end
            end
            PS_DOZE, PS_NAP, PS_SLEEP: begin
                if (wake) begin
                    s_d.ps = PS_FULL;
                end
            end
            default: s_d.ps = PS_FULL;
        endcase
        // Any way back to full drops the handshake and the enable bit,
        // so the core does not fall straight back into low power
        if (s_d.ps == PS_FULL && s_q.ps != PS_FULL) begin
            s_d.quiesce_request                    = 1'b0;
            s_d.tgt                     = MODE_NONE;
            s_d.mstate[`MSTATE_POW_BIT] = 1'b0;
        end

        // Sticky events: a set in the clearing cycle wins
        ev_set                = 4'h0;
        ev_set[`EV_EXT_BIT]   = ev_ext;
        ev_set[`EV_PMI_BIT]   = ev_pmi;
        ev_set[`EV_DEC_BIT]   = ev_dec;
        ev_set[`EV_WAKE_BIT]  = wake && s_q.ps != PS_FULL;
        s_d.stat = (s_q.stat & ~ev_clr) | ev_set;

        // Outputs of the next state
        s_d.halt    = is_low(s_d.ps);
        s_d.snoop   = !is_quiet(s_d.ps);
        s_d.dec_run = s_d.ps != PS_SLEEP;
        if (s_d.ps == PS_SLEEP) begin
            s_d.div = DEC_DIV - 8'h01;
        end

        // Hard reset pin returns to full power, gating off
        // It acts as a synchronous reset; a bus write in its data phase is lost
        if (pins_s[3]) begin
            s_d = CTRL_RST;
        end

        s_d.irq = |(s_d.stat & s_d.mask);

        // Address phase; read data taken after this cycle's write lands
        s_d.a_act = hsel_i & htrans_i[1] & hready_i & (hsize_i == `HSIZE_WORD);
        s_d.a_wr  = hwrite_i;
        s_d.a_ofs = haddr_i[7:0];
        s_d.rdata = (s_d.a_act && !hwrite_i) ? rd_reg(s_d, haddr_i[7:0]) : 32'h0000_0000;
        // Zero wait states: every access completes in its data phase
        s_d.hready = 1'b1;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs, all from flops but the tied-low response
    // ****************************************************************
    assign hrdata_o          = s_q.rdata;
    assign hreadyout_o       = s_q.hready;
    assign hresp_o           = 1'b0;
    assign unit_clk_en_o     = gif.clk_en;
    assign quiesce_request_o = s_q.quiesce_request;
    assign snoop_en_o        = s_q.snoop;
    assign units_halted_o    = s_q.halt;
    assign dec_running_o     = s_q.dec_run;
    assign irq_o             = s_q.irq;
endmodule

/* hw/pm_regs.svh */
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PM_OFS_HWCFG    8'h00
`define PM_OFS_MSTATE   8'h04
`define PM_OFS_STATUS   8'h08
`define PM_OFS_IRQ_STAT 8'h0C
`define PM_OFS_IRQ_MASK 8'h10
`define PM_OFS_DEC      8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define HWCFG_DOZE_BIT  8
`define HWCFG_NAP_BIT   9
`define HWCFG_SLEEP_BIT 10
`define HWCFG_GATE_BIT  11
`define MSTATE_POW_BIT  0
`define EV_EXT_BIT      0
`define EV_PMI_BIT      1
`define EV_DEC_BIT      2
`define EV_WAKE_BIT     3
`define STATUS_QUIESCE_REQUEST_BIT 3
`define STATUS_GATE_BIT 4

// ****************************************************************
// Reset values, timing counts and the word transfer size
// ****************************************************************
`define HWCFG_RST       32'h0000_0000
`define MSTATE_RST      32'h0000_0000
`define DEC_RST         32'hFFFF_FFFF
`define PM_SETTLE_CYC   4'h4
`define DEC_DIV_CYC     8'h08
`define HSIZE_WORD      3'h2

`endif

/* hw/pm_pkg.sv */
package pm_pkg;

    typedef enum logic [2:0] {
        PS_FULL    = 3'h0,
        PS_QUIESCE = 3'h1,
        PS_SETTLE  = 3'h3,
        PS_NAP     = 3'h2,
        PS_SLEEP   = 3'h7,
        PS_DOZE    = 3'h6
    } pstate_t;

    typedef enum logic [1:0] {
        MODE_NONE  = 2'h0,
        MODE_DOZE  = 2'h1,
        MODE_NAP   = 2'h2,
        MODE_SLEEP = 2'h3
    } mode_t;

    typedef struct packed {
        pstate_t     ps;
        mode_t       tgt;
        logic [3:0]  settle;
        logic [31:0] hwcfg;
        logic [31:0] mstate;
        logic [31:0] dec;
        logic [7:0]  div;
        logic [3:0]  stat;
        logic [3:0]  mask;
        logic        ext_q;
        logic        pmi_q;
        logic        a_act;
        logic        a_wr;
        logic [7:0]  a_ofs;
        logic [31:0] rdata;
        logic        hready;
        logic        irq;
        logic        quiesce_request;
        logic        snoop;
        logic        halt;
        logic        dec_run;
    } ctrl_t;

endpackage

/* hw/gate_if.sv */
`timescale 1ns/100ps
interface gate_if #(parameter int N = 5);
    logic         gating_on;
    logic         hold;
    logic [N-1:0] req;
    logic [N-1:0] clk_en;

    modport ctrl (output gating_on, output hold, output req, input clk_en);
    modport gate (input gating_on, input hold, input req, output clk_en);
endinterface

/* hw/pm_sync.sv */
`timescale 1ns/100ps
module pm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] q;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    // A change is taken only once the second and third stages agree
    always_comb begin
        s_d    = s_q;
        s_d.f1 = d_i;
        s_d.f2 = s_q.f1;
        s_d.f3 = s_q.f2;
        s_d.q  = (~(s_q.f2 ^ s_q.f3) & s_q.f3) | ((s_q.f2 ^ s_q.f3) & s_q.q);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.q;
endmodule

/* hw/unit_gate.sv */
`timescale 1ns/100ps
module unit_gate #(
    parameter int N = 5
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    gate_if.gate      gif
);
    typedef struct packed {
        logic [N-1:0] en;
    } gate_t;

    gate_t s_q;
    gate_t s_d;

    // Dispatch raises a unit's request one cycle ahead, so the registered
    // enable lines up with the cycle the unit actually works
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < N; i++) begin
            if (gif.hold) begin
                s_d.en[i] = 1'b0;
            end else if (!gif.gating_on) begin
                s_d.en[i] = 1'b1;
            end else begin
                s_d.en[i] = gif.req[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '{en: {N{1'b1}}};
        end else begin
            s_q <= s_d;
        end
    end

    assign gif.clk_en = s_q.en;
endmodule

/* bench/qsys_model.sv */
`timescale 1ns/100ps
module qsys_model (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic quiesce_request_i,
    input  wire logic [31:0] ack_delay_i,
    output logic             quiesce_acknowledge_o
);
    int cnt_q;

    // Delay stands for outstanding bus work the system must drain first
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 0;
            quiesce_acknowledge_o <= 1'b0;
        end else if (!quiesce_request_i) begin
            cnt_q <= 0;
            quiesce_acknowledge_o <= 1'b0;
        end else if (cnt_q >= ack_delay_i) begin
            quiesce_acknowledge_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule

/* bench/pm_checker.sv */
`timescale 1ns/100ps
module pm_checker #(
    parameter int N_UNITS = 5
) (
    input wire logic               clk_i,
    input wire logic               arst_n_i,
    input wire logic               ext_int_i,
    input wire logic               power_mgmt_interrupt_i,
    input wire logic               quiesce_acknowledge_i,
    input wire logic               hard_reset_in_i,
    input wire logic               hreadyout_o,
    input wire logic               hresp_o,
    input wire logic [N_UNITS-1:0] unit_clk_en_o,
    input wire logic               quiesce_request_o,
    input wire logic               snoop_en_o,
    input wire logic               units_halted_o,
    input wire logic               dec_running_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_bus_ok;
        hreadyout_o && !hresp_o;
    endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");

    property p_halt_gates;
        units_halted_o |-> unit_clk_en_o == '0;
    endproperty
    a_halt_gates: assert property (p_halt_gates) else $error("unit clock on while halted");

    property p_nap_quiesce_request;
        units_halted_o && !snoop_en_o |-> quiesce_request_o;
    endproperty
    a_nap_quiesce_request: assert property (p_nap_quiesce_request) else $error("snoop off without request");

    property p_entry_ack;
        $rose(units_halted_o) && !snoop_en_o |-> $past(quiesce_acknowledge_i, 6);
    endproperty
    a_entry_ack: assert property (p_entry_ack) else $error("nap or sleep before ack");

    property p_doze_snoop;
        units_halted_o && !quiesce_request_o |-> snoop_en_o && dec_running_o;
    endproperty
    a_doze_snoop: assert property (p_doze_snoop) else $error("doze lost snoop");

    property p_dec_stop;
        !dec_running_o |-> units_halted_o && !snoop_en_o && quiesce_request_o;
    endproperty
    a_dec_stop: assert property (p_dec_stop) else $error("timer stopped outside sleep");

    property p_exit_full;
        $fell(units_halted_o) |-> !quiesce_request_o && snoop_en_o && dec_running_o;
    endproperty
    a_exit_full: assert property (p_exit_full) else $error("exit not to full power");

    property p_wake;
        ($rose(ext_int_i) || $rose(power_mgmt_interrupt_i)) && units_halted_o
            |-> ##[1:6] !units_halted_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake after interrupt");

    property p_hard_rst;
        hard_reset_in_i [*6] |-> ##1 (&unit_clk_en_o && !units_halted_o && !quiesce_request_o);
    endproperty
    a_hard_rst: assert property (p_hard_rst) else $error("hard reset image wrong");
endmodule

bind cpu_power_mode_controller pm_checker #(.N_UNITS(N_UNITS)) u_chk (
    .clk_i, .arst_n_i, .ext_int_i, .power_mgmt_interrupt_i, .quiesce_acknowledge_i,
    .hard_reset_in_i, .hreadyout_o, .hresp_o, .unit_clk_en_o, .quiesce_request_o,
    .snoop_en_o, .units_halted_o, .dec_running_o);

/* bench/tb_top.sv */
`timescale 1ns/100ps
`include "pm_regs.svh"
module tb_top;
    import pm_pkg::*;
    localparam logic [31:0] DOZE  = 32'h1 << `HWCFG_DOZE_BIT;
    localparam logic [31:0] NAP   = 32'h1 << `HWCFG_NAP_BIT;
    localparam logic [31:0] SLEEP = 32'h1 << `HWCFG_SLEEP_BIT;
    localparam logic [31:0] GATE  = 32'h1 << `HWCFG_GATE_BIT;
    logic        clk_i    = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, ext_int = 1'b0, pmi = 1'b0, hard_rst = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize  = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [4:0]  unit_req = 5'h00, clk_en;
    logic        hready, hresp, quiesce_request, quiesce_acknowledge, snoop, halted, dec_run, irq;
    int          ack_delay   = 0;
    int          num_errors  = 0;
    int          comparisons = 0;

    initial forever #2 clk_i = ~clk_i;

    cpu_power_mode_controller DUT (.clk_i, .arst_n_i, .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .ext_int_i(ext_int), .power_mgmt_interrupt_i(pmi), .quiesce_acknowledge_i(quiesce_acknowledge),
        .hard_reset_in_i(hard_rst), .unit_req_i(unit_req), .unit_clk_en_o(clk_en),
        .quiesce_request_o(quiesce_request), .snoop_en_o(snoop), .units_halted_o(halted),
        .dec_running_o(dec_run), .irq_o(irq));

    qsys_model u_sys (.clk_i, .arst_n_i, .quiesce_request_i(quiesce_request), .ack_delay_i(ack_delay),
        .quiesce_acknowledge_o(quiesce_acknowledge));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
        @(posedge clk_i);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= `HSIZE_WORD;
        haddr  <= {24'h0, ofs};
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rd = hrdata;
    endtask

    task automatic wr32(input logic [7:0] ofs, input logic [31:0] wd);
        bus(1'b1, ofs, wd);
    endtask

    task automatic rd32(input logic [7:0] ofs);
        bus(1'b0, ofs, 32'h0);
    endtask

    // Bounded wait; a stuck state shows up as a halted mismatch
    task automatic wait_halt(input logic v, input int n);
        for (int i = 0; i < n && halted !== v; i++) @(posedge clk_i);
        chk("halted", {31'h0, v}, {31'h0, halted});
    endtask

    task automatic pulse(input logic use_pmi);
        @(posedge clk_i);
        if (use_pmi) pmi <= 1'b1;
        else ext_int <= 1'b1;
        repeat (4) @(posedge clk_i);
        pmi     <= 1'b0;
        ext_int <= 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd32(`PM_OFS_HWCFG);
        chk("hwcfg", `HWCFG_RST, rd);
        rd32(8'h3C);
        chk("unmapped", 32'h0, rd);
        chk("clk_en", 32'h1F, {27'h0, clk_en});
    endtask

    task automatic t_gate();
        wr32(`PM_OFS_HWCFG, GATE);
        unit_req <= 5'h0A;
        repeat (3) @(posedge clk_i);
        chk("gated", 32'h0A, {27'h0, clk_en});
        rd32(`PM_OFS_STATUS);
        chk("gate_flag", 32'h1, {31'h0, rd[`STATUS_GATE_BIT]});
        wr32(`PM_OFS_HWCFG, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("ungated", 32'h1F, {27'h0, clk_en});
    endtask

    task automatic t_doze();
        wr32(`PM_OFS_IRQ_MASK, 32'h0);
        wr32(`PM_OFS_HWCFG, DOZE);
        repeat (20) @(posedge clk_i);
        chk("no_pow", 32'h0, {31'h0, halted});
        wr32(`PM_OFS_MSTATE, 32'h1);
        wait_halt(1'b1, 30);
        chk("doze_snoop", 32'h1, {31'h0, snoop});
        wr32(`PM_OFS_HWCFG, NAP);
        repeat (20) @(posedge clk_i);
        rd32(`PM_OFS_STATUS);
        chk("doze_kept", {29'h0, PS_DOZE}, {29'h0, rd[2:0]});
        pulse(1'b0);
        wait_halt(1'b0, 10);
        rd32(`PM_OFS_IRQ_STAT);
        chk("ext_stat", 32'h9, rd);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr32(`PM_OFS_IRQ_MASK, 32'hF);
        repeat (2) @(posedge clk_i);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr32(`PM_OFS_IRQ_STAT, 32'hF);
        repeat (2) @(posedge clk_i);
        chk("irq_off", 32'h0, {31'h0, irq});
        rd32(`PM_OFS_MSTATE);
        chk("pow_clr", 32'h0, rd);
    endtask

    task automatic t_nap();
        ack_delay = 8;
        wr32(`PM_OFS_DEC, 32'h40);
        wr32(`PM_OFS_MSTATE, 32'h1);
        repeat (4) @(posedge clk_i);
        chk("quiesce_request", 32'h1, {31'h0, quiesce_request});
        chk("wait_ack", 32'h0, {31'h0, halted});
        wait_halt(1'b1, 40);
        chk("nap_snoop", 32'h0, {31'h0, snoop});
        chk("nap_dec", 32'h1, {31'h0, dec_run});
        wait_halt(1'b0, 700);
        rd32(`PM_OFS_IRQ_STAT);
        chk("dec_stat", 32'hC, rd);
        wr32(`PM_OFS_IRQ_STAT, 32'hF);
    endtask

    task automatic t_sleep();
        ack_delay = 0;
        wr32(`PM_OFS_DEC, 32'h10);
        wr32(`PM_OFS_HWCFG, SLEEP);
        wr32(`PM_OFS_MSTATE, 32'h1);
        wait_halt(1'b1, 30);
        chk("sleep_dec", 32'h0, {31'h0, dec_run});
        rd32(`PM_OFS_STATUS);
        chk("sleep_state", {29'h0, PS_SLEEP}, {29'h0, rd[2:0]});
        repeat (150) @(posedge clk_i);
        chk("still_asleep", 32'h1, {31'h0, halted});
        pulse(1'b1);
        wait_halt(1'b0, 10);
        rd32(`PM_OFS_IRQ_STAT);
        chk("pmi_stat", 32'hA, rd);
    endtask

    task automatic t_two_bits();
        wr32(`PM_OFS_HWCFG, DOZE | NAP);
        wr32(`PM_OFS_MSTATE, 32'h1);
        repeat (20) @(posedge clk_i);
        chk("two_bits", 32'h0, {31'h0, halted});
        rd32(`PM_OFS_MSTATE);
        chk("pow_kept", 32'h1, rd);
    endtask

    task automatic t_hard();
        wr32(`PM_OFS_HWCFG, GATE);
        hard_rst <= 1'b1;
        repeat (6) @(posedge clk_i);
        hard_rst <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd32(`PM_OFS_HWCFG);
        chk("hard_hwcfg", 32'h0, rd);
        chk("hard_clk_en", 32'h1F, {27'h0, clk_en});
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_gate();
        t_doze();
        t_nap();
        t_sleep();
        t_two_bits();
        t_hard();
        report_and_stop();
    end

    // Whole run is under 1000 cycles; five thousand leaves ample margin
    initial begin
        #20000;
        num_errors++;
        report_and_stop();
    end
endmodule
